// ### verilog/asf_pkg.sv
// asf_pkg: constants and types shared by the serial frame sequencer files.
// assumes a 200 MHz core clock; the link side runs on the host's I/O clock.
package asf_pkg;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 4;
  localparam int RES_BITS = 12;
  localparam int FRAME_CLKS = 12;
  localparam int ADDR_READY_RISE = 4;
  localparam int SAMPLE_START_FALL = 4;
  localparam int CNT_W = 4;
  // configuration nibble, low half of the command word
  localparam int CFG_LSB_FIRST_BIT = 3;
  localparam int CFG_EOC_MODE_BIT = 2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_NS = 3000;
  // least time, so rounded up to whole cycles
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_W = 10;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [RES_BITS-1:0] RESULT_RST = 12'h000;
  localparam logic [CMD_BITS-1:0] CMD_RST = 8'h00;
  localparam logic STATUS_RST = 1'b1;

  typedef enum logic {
    ASF_IDLE,
    ASF_CONV
  } asf_conv_t;

endpackage

// ### verilog/asf_link_if.sv
// asf_link_if: signals between the core domain and the I/O clock domain.
// assumes the word fields only change while no frame is running.
`timescale 1ns/1ps
`default_nettype none
interface asf_link_if;
  logic [asf_pkg::RES_BITS-1:0] word;
  logic lsb_first;
  logic [asf_pkg::CMD_BITS-1:0] cmd;
  logic frame_tgl;
  logic rise_tgl;

  modport link (
    input word,
    input lsb_first,
    output cmd,
    output frame_tgl,
    output rise_tgl
  );

  modport core (
    output word,
    output lsb_first,
    input cmd,
    input frame_tgl,
    input rise_tgl
  );
endinterface
`default_nettype wire

// ### verilog/asf_link.sv
// asf_link: frame logic clocked by the host I/O clock.
// assumes cs_n is high between frames and the I/O clock idles low (mode 0).
`timescale 1ns/1ps
`default_nettype none
module asf_link (
  input wire logic rst_n,
  input wire logic io_clk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  output logic [asf_pkg::ADDR_BITS-1:0] mux_addr,
  output logic sample_en,
  asf_link_if.link lk
);

  // ****************************************************************
  // state: frame parts clear on cs_n high, kept parts on rst_n
  // ****************************************************************
  typedef struct packed {
    logic [asf_pkg::CNT_W-1:0] cnt;
    logic [asf_pkg::CMD_BITS-1:0] sreg;
    logic [asf_pkg::ADDR_BITS-1:0] addr;
  } asf_rise_t;

  typedef struct packed {
    logic [asf_pkg::CNT_W-1:0] cnt;
    logic sample;
  } asf_fall_t;

  typedef struct packed {
    logic rtgl;
  } asf_rkeep_t;

  typedef struct packed {
    logic [asf_pkg::CMD_BITS-1:0] cmd;
    logic ftgl;
  } asf_fkeep_t;

  asf_rise_t r_q, r_d;
  asf_fall_t f_q, f_d;
  asf_rkeep_t rk_q, rk_d;
  asf_fkeep_t fk_q, fk_d;
  logic [asf_pkg::CNT_W-1:0] pos;
  logic frame_clr;

  // reset clears the frame parts too, so they are defined before the first select
  assign frame_clr = cs_n | ~rst_n;

  always_comb begin
    r_d = r_q;
    rk_d.rtgl = ~rk_q.rtgl;
    if (r_q.cnt < asf_pkg::CNT_W'(asf_pkg::CMD_BITS)) begin
      r_d.sreg = {r_q.sreg[asf_pkg::CMD_BITS-2:0], din};
      r_d.cnt = r_q.cnt + asf_pkg::CNT_W'(1);
      if (r_q.cnt == asf_pkg::CNT_W'(asf_pkg::ADDR_READY_RISE - 1)) begin
        r_d.addr = {r_q.sreg[asf_pkg::ADDR_BITS-2:0], din};
      end
    end
  end

  always_comb begin
    f_d = f_q;
    fk_d = fk_q;
    if (f_q.cnt < asf_pkg::CNT_W'(asf_pkg::FRAME_CLKS)) begin
      f_d.cnt = f_q.cnt + asf_pkg::CNT_W'(1);
      if (f_d.cnt == asf_pkg::CNT_W'(asf_pkg::SAMPLE_START_FALL)) begin
        f_d.sample = 1'b1;
      end
      if (f_d.cnt == asf_pkg::CNT_W'(asf_pkg::FRAME_CLKS)) begin
        // last falling edge: sampling stops, core takes over
        f_d.sample = 1'b0;
        fk_d.ftgl = ~fk_q.ftgl;
        fk_d.cmd = r_q.sreg;
      end
    end
  end

  // cs_n high holds the frame counters cleared, so its fall starts a clean frame
  always_ff @(posedge io_clk or posedge frame_clr) begin
    if (frame_clr) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(negedge io_clk or posedge frame_clr) begin
    if (frame_clr) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  always_ff @(posedge io_clk or negedge rst_n) begin
    if (!rst_n) begin
      rk_q <= '0;
    end else begin
      rk_q <= rk_d;
    end
  end

  always_ff @(negedge io_clk or negedge rst_n) begin
    if (!rst_n) begin
      fk_q <= '{cmd: asf_pkg::CMD_RST, ftgl: 1'b0};
    end else begin
      fk_q <= fk_d;
    end
  end

  // ****************************************************************
  // pins and crossing outputs
  // ****************************************************************
  // fall count indexes the result, so each falling edge moves to the next bit
  always_comb begin
    if (lk.lsb_first) begin
      pos = f_q.cnt;
    end else begin
      pos = asf_pkg::CNT_W'(asf_pkg::RES_BITS - 1) - f_q.cnt;
    end
  end

  assign dout_o = (f_q.cnt < asf_pkg::CNT_W'(asf_pkg::RES_BITS)) ? lk.word[pos] : 1'b0;
  assign dout_oe = ~cs_n;
  assign mux_addr = r_q.addr;
  assign sample_en = f_q.sample;
  assign lk.cmd = fk_q.cmd;
  assign lk.frame_tgl = fk_q.ftgl;
  assign lk.rise_tgl = rk_q.rtgl;

endmodule // asf_link
`default_nettype wire

// ### verilog/asf_seq.sv
// asf_seq: serial frame sequencer and conversion status for a serial SAR converter.
// assumes a mode-0 host serial port on cs_n, io_clk and din, and a SAR core that
// presents its result on sar_result by the end of the conversion time.
`timescale 1ns/1ps
`default_nettype none

module asf_seq (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic io_clk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_o,
  output logic dout_oe,
  output logic status_o,
  output logic [asf_pkg::ADDR_BITS-1:0] mux_addr,
  output logic sample_en,
  output logic conv_busy,
  output logic [asf_pkg::ADDR_BITS-1:0] conv_channel,
  input wire logic [asf_pkg::RES_BITS-1:0] sar_result
);

  // ****************************************************************
  // link side
  // ****************************************************************
  asf_link_if lk ();

  asf_link u_link (
    .rst_n(rst_n),
    .io_clk(io_clk),
    .cs_n(cs_n),
    .din(din),
    .dout_o(dout_o),
    .dout_oe(dout_oe),
    .mux_addr(mux_addr),
    .sample_en(sample_en),
    .lk(lk.link)
  );

  // ****************************************************************
  // core state
  // ****************************************************************
  typedef struct packed {
    logic fr1;
    logic fr2;
    logic fr3;
    logic ri1;
    logic ri2;
    logic ri3;
    asf_pkg::asf_conv_t st;
    logic [asf_pkg::CONV_W-1:0] cnt;
    logic [asf_pkg::ADDR_BITS-1:0] chan;
    logic eoc_mode;
    logic lsb_next;
    logic [asf_pkg::RES_BITS-1:0] result;
    logic lsb_out;
    logic status;
  } asf_core_t;

  localparam asf_core_t CORE_RST = '{
    fr1: 1'b0,
    fr2: 1'b0,
    fr3: 1'b0,
    ri1: 1'b0,
    ri2: 1'b0,
    ri3: 1'b0,
    st: asf_pkg::ASF_IDLE,
    cnt: '0,
    chan: '0,
    eoc_mode: 1'b0,
    lsb_next: 1'b0,
    result: asf_pkg::RESULT_RST,
    lsb_out: 1'b0,
    status: asf_pkg::STATUS_RST
  };

  asf_core_t c_q, c_d;
  logic frame_end;
  logic rise_ev;
  logic done;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    c_d = c_q;
    // two-flop synchronisers; only the second stage and later are read
    c_d.fr1 = lk.frame_tgl;
    c_d.fr2 = c_q.fr1;
    c_d.fr3 = c_q.fr2;
    c_d.ri1 = lk.rise_tgl;
    c_d.ri2 = c_q.ri1;
    c_d.ri3 = c_q.ri2;
    frame_end = c_q.fr2 ^ c_q.fr3;
    rise_ev = c_q.ri2 ^ c_q.ri3;
    done = 1'b0;

    case (c_q.st)
      asf_pkg::ASF_IDLE: begin
        if (frame_end) begin
          // command word is stable by now: it was written with the toggle
          c_d.st = asf_pkg::ASF_CONV;
          c_d.cnt = '0;
          c_d.chan = lk.cmd[asf_pkg::CMD_BITS-1 -: asf_pkg::ADDR_BITS];
          c_d.eoc_mode = lk.cmd[asf_pkg::CFG_EOC_MODE_BIT];
          c_d.lsb_next = lk.cmd[asf_pkg::CFG_LSB_FIRST_BIT];
        end
      end
      asf_pkg::ASF_CONV: begin
        // a frame ending mid-conversion is ignored; the host must wait
        if (c_q.cnt == asf_pkg::CONV_W'(asf_pkg::CONV_CYCLES - 1)) begin
          c_d.st = asf_pkg::ASF_IDLE;
          c_d.result = sar_result;
          c_d.lsb_out = c_q.lsb_next;
          done = 1'b1;
        end else begin
          c_d.cnt = c_q.cnt + asf_pkg::CONV_W'(1);
        end
      end
      default: begin
        c_d.st = asf_pkg::ASF_IDLE;
      end
    endcase

    // status pin; a completion wins over a same-cycle interrupt release
    if (c_q.st == asf_pkg::ASF_IDLE && frame_end && lk.cmd[asf_pkg::CFG_EOC_MODE_BIT]) begin
      c_d.status = 1'b0;
    end
    if (rise_ev && !c_q.eoc_mode) begin
      c_d.status = 1'b1;
    end
    if (done) begin
      c_d.status = c_q.eoc_mode;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // the result word is only rewritten at conversion end, which the host
  // waits for before selecting, so the link reads it while it stands still
  assign lk.word = c_q.result;
  assign lk.lsb_first = c_q.lsb_out;
  assign status_o = c_q.status;
  assign conv_busy = (c_q.st == asf_pkg::ASF_CONV);
  assign conv_channel = c_q.chan;

endmodule // asf_seq
`default_nettype wire

// ### tb/asf_seq_properties.sv
// asf_seq_properties: port-level checks for asf_seq.
// assumes binding to asf_seq; the I/O clock side is cleared by cs_n high.
`timescale 1ns/1ps
`default_nettype none
module asf_seq_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic io_clk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic status_o,
  input wire logic [3:0] mux_addr,
  input wire logic sample_en,
  input wire logic conv_busy
);
  logic [9:0] busy_cnt_q;
  logic [3:0] rise_cnt_q;
  logic [3:0] fall_cnt_q;
  logic [3:0] addr_sh_q;
  logic clr;

  // reset clears the frame counters as well, so no unknown reaches a property
  assign clr = cs_n | ~rst_n;

  // wraps after 1024 busy cycles, far beyond any legal conversion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) busy_cnt_q <= 10'h000;
    else busy_cnt_q <= conv_busy ? busy_cnt_q + 10'h001 : 10'h000;
  end
  always_ff @(posedge io_clk or posedge clr) begin
    if (clr) begin
      rise_cnt_q <= 4'h0;
      addr_sh_q <= 4'h0;
    end else begin
      if (rise_cnt_q < 4'hf) rise_cnt_q <= rise_cnt_q + 4'h1;
      if (rise_cnt_q < 4'h4) addr_sh_q <= {addr_sh_q[2:0], din};
    end
  end
  always_ff @(negedge io_clk or posedge clr) begin
    if (clr) fall_cnt_q <= 4'h0;
    else if (fall_cnt_q < 4'hf) fall_cnt_q <= fall_cnt_q + 4'h1;
  end

  oe_select_a: assert property (@(posedge clock) disable iff (!rst_n)
    dout_oe == !cs_n) else $error("output enable differs from select");
  addr_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    cs_n |-> mux_addr == 4'h0) else $error("address kept while deselected");
  addr_value_a: assert property (@(posedge io_clk) disable iff (cs_n)
    rise_cnt_q >= 4'h4 |-> mux_addr == addr_sh_q) else $error("address wrong");
  sample_window_a: assert property (@(posedge io_clk) disable iff (cs_n)
    sample_en == (fall_cnt_q >= 4'h4 && fall_cnt_q < 4'hc)) else $error("window");
  dout_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(dout_o) && !cs_n && !$past(cs_n) |-> !io_clk) else $error("dout edge");
  conv_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(sample_en) && !conv_busy |-> ##[1:6] conv_busy) else $error("no start");
  conv_length_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(conv_busy) |-> busy_cnt_q >= 10'h257 && busy_cnt_q <= 10'h259)
    else $error("conversion length wrong");
  status_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    busy_cnt_q > 10'h004 && busy_cnt_q < 10'h24e |-> $stable(status_o))
    else $error("status moved during conversion");
endmodule // asf_seq_properties

bind asf_seq asf_seq_properties chk (.clock, .rst_n, .io_clk, .cs_n, .din, .dout_o,
  .dout_oe, .status_o, .mux_addr, .sample_en, .conv_busy);
`default_nettype wire

// ### tb/asf_host_model.sv
// asf_host_model: mode-0 host serial port driving one frame at a time.
// assumes a 12 ns I/O clock that stands still low between frames.
`timescale 1ns/1ps
`default_nettype none
module asf_host_model (
  output logic io_clk,
  output logic cs_n,
  output logic din,
  input wire logic dout_o
);
  initial begin
    io_clk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // command goes out msb first, data is taken on rising edges
  task automatic frame(input logic [7:0] cmd, output logic [11:0] rx);
    int i;
    #3.3 cs_n = 1'b0;
    din = cmd[7];
    for (i = 0; i < 12; i++) begin
      #6 io_clk = 1'b1;
      rx = {rx[10:0], dout_o};
      #6 io_clk = 1'b0;
      din = (i < 7) ? cmd[6-i] : ~din;
    end
    #6 cs_n = 1'b1;
    // no pull on the line, so an idle value must not look like data
    din = ~din;
  endtask
endmodule // asf_host_model
`default_nettype wire

// ### tb/test_adc_serial_frame_sequencer.sv
// test_adc_serial_frame_sequencer: frames, readout order and status roles.
// assumes asf_seq with its bound checker and the host model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_frame_sequencer;
  typedef struct packed {
    logic [7:0] cmd;
    logic [11:0] sar;
    logic [11:0] exp_rx;
  } asf_row_t;

  logic clock, rst_n, io_clk, cs_n, din, dout_o, dout_oe, status_o, sample_en, conv_busy;
  logic [3:0] mux_addr, conv_channel;
  logic [11:0] sar_result, rx;
  int mismatches, n_tests;
  // row 0 reads the reset result; each later readout is the previous row's result in the previous row's bit order;
  // rows 2 and 3 follow an interrupt completion, so their busy status shows the release
  asf_row_t rows [5] = '{'{8'h54, 12'ha5c, 12'h000}, '{8'h38, 12'h3c1, 12'ha5c},
    '{8'hf8, 12'h801, 12'h83c}, '{8'h00, 12'h7e6, 12'h801}, '{8'ha4, 12'h5a3, 12'h7e6}};

  asf_seq dut (.clock, .rst_n, .io_clk, .cs_n, .din, .dout_o, .dout_oe, .status_o,
    .mux_addr, .sample_en, .conv_busy, .conv_channel, .sar_result);
  asf_host_model host (.io_clk, .cs_n, .din, .dout_o);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_status(input logic v);
    int k;
    for (k = 0; k < 1000 && status_o !== v; k++) @(negedge clock);
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    sar_result = 12'h000;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(negedge clock);
    check("reset status", 12'(status_o), 12'h001);
    check("idle enable", 12'(dout_oe), 12'h000);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    foreach (rows[i]) begin
      sar_result <= rows[i].sar;
      host.frame(rows[i].cmd, rx);
      check("readout", rx, rows[i].exp_rx);
      repeat (8) @(negedge clock);
      check("busy status", 12'(status_o), 12'(!rows[i].cmd[2]));
      check("busy", 12'(conv_busy), 12'h001);
      wait_status(rows[i].cmd[2]);
      repeat (20) @(negedge clock);
      check("done status", 12'(status_o), 12'(rows[i].cmd[2]));
      check("channel", 12'(conv_channel), 12'(rows[i].cmd[7:4]));
      @(posedge clock);
    end
    // reset in mid-conversion must drop the busy state and the result
    host.frame(8'h54, rx);
    check("readout before reset", rx, 12'h5a3);
    repeat (20) @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(negedge clock);
    check("mid reset status", 12'(status_o), 12'h001);
    check("mid reset busy", 12'(conv_busy), 12'h000);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    host.frame(8'h04, rx);
    check("readout after reset", rx, 12'h000);
    report_and_stop();
  end
endmodule // test_adc_serial_frame_sequencer
`default_nettype wire
